// >>> pas_pkg.sv
// shared constants and types for the pipelined converter sample output block
package pas_pkg;

  // ==========================================================================
  // word layout and full scale
  // ==========================================================================
  localparam int WORD_W  = 10;                   // parallel sample word width
  localparam int AIN_W   = 12;                   // signed held-input width in lsb units
  localparam int FLAG_POS = 10;                  // range flag position in a buffered word
  localparam int BUF_W   = 11;                   // buffered word: flag plus sample bits
  localparam int BUF_DEPTH = 16;                 // words of buffering toward the capture side
  localparam logic signed [12:0] CODE_OFFSET = 13'h0200; // mid scale in offset binary
  localparam logic signed [12:0] CODE_TOP    = 13'h03FF; // largest offset binary code
  localparam logic signed [12:0] CODE_BOTTOM = 13'h0000; // smallest offset binary code
  localparam int PIPE_LATENCY = 5;               // clocks from sample edge to word on pins
  localparam int NUM_STAGES   = 6;               // pipelined conversion stages

  // ==========================================================================
  // stage resolution: stages 1 to 4 give two bits, stages 5 and 6 one bit
  // ==========================================================================
  localparam int WIDE_BITS   = 2;
  localparam int NARROW_BITS = 1;

  // ==========================================================================
  // four-level mode pin codes
  // ==========================================================================
  localparam logic [1:0] MODE_GND        = 2'h0; // offset binary, stabilizer off
  localparam logic [1:0] MODE_THIRD      = 2'h1; // offset binary, stabilizer on
  localparam logic [1:0] MODE_TWO_THIRDS = 2'h2; // twos complement, stabilizer on
  localparam logic [1:0] MODE_FULL       = 2'h3; // twos complement, stabilizer off

  typedef enum logic [1:0] {
    PAS_RUN     = 2'b00,
    PAS_RUN_HIZ = 2'b01,
    PAS_NAP     = 2'b10,
    PAS_SLEEP   = 2'b11
  } pas_pwr_t;

  typedef struct packed {
    logic             h_valid;  // input hold
    logic [9:0]       h_res;
    logic             h_ovr;
    logic             a_valid;  // after stages 1 and 2
    logic [9:0]       a_res;
    logic [3:0]       a_dig;
    logic             a_ovr;
    logic             b_valid;  // after stages 3 and 4
    logic [9:0]       b_res;
    logic [7:0]       b_dig;
    logic             b_ovr;
    logic             c_valid;  // corrected word toward the buffer
    logic [10:0]      c_word;
    pas_pwr_t         pwr;
    logic             twos;
    logic             stab_on;
    logic             drive_n;
  } pas_state_t;

  localparam pas_state_t STATE_RST = '{pwr: PAS_SLEEP, drive_n: 1'b1, default: '0};

endpackage

// >>> pas_fifo.sv
// word buffer between the correction logic and the capture-side pins
`timescale 1ns/10ps
`default_nettype none
module pas_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 16
) (
  input  wire logic                       clk,
  input  wire logic                       nrst,
  input  wire logic                       clk_en,
  input  wire logic                       in_valid,
  input  wire logic [WIDTH-1:0]           in_data,
  output logic                            in_ready,
  output logic                            out_valid,
  output logic [WIDTH-1:0]                out_data,
  input  wire logic                       out_ready,
  output logic [$clog2(DEPTH+1)-1:0]      level
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH+1);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0]            wr_ptr;
    logic [PTR_W-1:0]            rd_ptr;
    logic [CNT_W-1:0]            count;
    logic                        full;
    logic                        out_valid;
    logic [WIDTH-1:0]            out_data;
  } pas_fifo_state_t;

  pas_fifo_state_t st;
  pas_fifo_state_t next_st;
  logic            push;
  logic            pop;

  // ==========================================================================
  // next state: output register refills from storage whenever it is free
  // ==========================================================================
  always_comb begin
    next_st = st;
    push = in_valid && !st.full;
    pop  = (st.count != '0) && (!st.out_valid || out_ready);
    if (st.out_valid && out_ready) begin
      next_st.out_valid = 1'b0;
    end
    if (pop) begin
      next_st.out_data  = st.mem[st.rd_ptr];
      next_st.out_valid = 1'b1;
      next_st.rd_ptr    = (st.rd_ptr == PTR_LAST) ? '0 : PTR_W'(st.rd_ptr + 1'b1);
    end
    if (push) begin
      next_st.mem[st.wr_ptr] = in_data;
      next_st.wr_ptr = (st.wr_ptr == PTR_LAST) ? '0 : PTR_W'(st.wr_ptr + 1'b1);
    end
    next_st.count = CNT_W'(st.count + CNT_W'(push) - CNT_W'(pop));
    next_st.full  = (next_st.count == CNT_FULL); // registered so in_ready is a flop
  end

  // ==========================================================================
  // state register, frozen while the clock enable is low
  // ==========================================================================
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign in_ready  = !st.full;
  assign out_valid = st.out_valid;
  assign out_data  = st.out_data;
  assign level     = st.count;

endmodule
`default_nettype wire

// >>> pas_top.sv
// digital side of a pipelined converter: hold, six stages, correction, output pins
//
// Operation
// RULE_01 - A new sample is held and a conversion starts at every rising clock edge.
// RULE_02 - The tracked input is frozen at the rising edge and handed to the first stage.
// RULE_03 - Each result reaches the pins five clocks after its sample, one result per clock; capture stalls delay words, a full buffer drops them.
// RULE_04 - Conversion runs through six stages, the fifth residue feeding the sixth stage.
// RULE_05 - Odd and even stages alternate, one delivering residue while the next acquires it.
// RULE_06 - Partial digits of all stages are time-aligned and merged before the output.
// RULE_07 - Power-down low and output enable low means converting with outputs driven.
// RULE_08 - Power-down low and output enable high means converting with outputs released.
// RULE_09 - Power-down high and output enable low means nap with outputs released.
// RULE_10 - Power-down high and output enable high means sleep with outputs released.
// RULE_11 - Each result is a ten-bit parallel word with bit 9 as the most significant bit.
// RULE_12 - The range flag is high when the input lies above or below full scale.
// RULE_13 - The four-level mode pin picks output format and the duty cycle stabilizer.
// RULE_14 - In twos complement the all-zeros and all-ones codes sit either side of mid scale.
// RULE_15 - Twos complement is offset binary with the top bit inverted; clipping saturates.
// RULE_16 - The range flag has the same latency as its data word and changes with it.
// RULE_17 - Capture registers words on a fixed edge and drops five results after nap or sleep.
`timescale 1ns/10ps
`default_nettype none
module pas_top
  import pas_pkg::*;
#(
  parameter int DEPTH = BUF_DEPTH
) (
  input  wire logic                     clk,
  input  wire logic                     nrst,
  input  wire logic                     clk_en,
  input  wire logic signed [AIN_W-1:0]  analog_in,
  input  wire logic                     power_down_select,
  input  wire logic                     output_enable_n,
  input  wire logic [1:0]               mode_level,
  input  wire logic                     capture_ready,
  output logic [WORD_W-1:0]             sample_word_bits,
  output logic                          range_exceeded_flag,
  output logic                          sample_oe_n,
  output logic                          sample_valid,
  output logic                          buffer_ready,
  output logic                          duty_stabilizer_on,
  output pas_pwr_t                      power_state
);

  pas_state_t             st;
  pas_state_t             next_st;
  logic signed [12:0]     shifted;
  logic                   run;
  logic [BUF_W-1:0]       buf_word;
  logic [$clog2(DEPTH+1)-1:0] buf_level;

  // ==========================================================================
  // helpers
  // ==========================================================================
  // clip the held input to the code range; saturation gives the extreme code
  function automatic logic [10:0] clip_code(input logic signed [AIN_W-1:0] v);
    logic signed [12:0] s;
    logic [10:0]        r;
    s = 13'(v) + CODE_OFFSET;
    if (s > CODE_TOP) begin
      r = {1'b1, CODE_TOP[9:0]};
    end else if (s < CODE_BOTTOM) begin
      r = {1'b1, CODE_BOTTOM[9:0]};
    end else begin
      r = {1'b0, s[9:0]};
    end
    return r;
  endfunction

  // expected buffered word for a sample, used by the checks below
  function automatic logic [10:0] exp_word(input logic signed [AIN_W-1:0] v,
                                           input logic [1:0] mode);
    logic [10:0] c;
    c = clip_code(v);
    if (mode[1]) begin
      c[9] = ~c[9];
    end
    return c;
  endfunction

  // ==========================================================================
  // next state
  // ==========================================================================
  assign run     = !power_down_select;
  assign shifted = 13'(analog_in) + CODE_OFFSET;

  always_comb begin
    logic [10:0] held;
    logic [9:0]  ob;
    next_st = st;
    held = clip_code(analog_in);
    ob   = '0;
    // power state straight from the two pins
    unique case ({power_down_select, output_enable_n})
      2'b00: next_st.pwr = PAS_RUN;     // RULE_07
      2'b01: next_st.pwr = PAS_RUN_HIZ; // RULE_08
      2'b10: next_st.pwr = PAS_NAP;     // RULE_09
      2'b11: next_st.pwr = PAS_SLEEP;   // RULE_10
    endcase
    next_st.drive_n = power_down_select || output_enable_n; // RULE_07 RULE_08 RULE_09 RULE_10
    // four-level mode pin
    unique case (mode_level)
      MODE_GND:        begin next_st.twos = 1'b0; next_st.stab_on = 1'b0; end // RULE_13
      MODE_THIRD:      begin next_st.twos = 1'b0; next_st.stab_on = 1'b1; end // RULE_13
      MODE_TWO_THIRDS: begin next_st.twos = 1'b1; next_st.stab_on = 1'b1; end // RULE_13
      MODE_FULL:       begin next_st.twos = 1'b1; next_st.stab_on = 1'b0; end // RULE_13
    endcase
    if (run) begin
      // hold: the edge freezes the tracked input and feeds stage 1
      next_st.h_valid = 1'b1;                     // RULE_01
      next_st.h_res   = held[9:0];                // RULE_02
      next_st.h_ovr   = held[10];                 // RULE_12
      // stages 1 and 2 resolve together on the same rising edge, with no separate phases
      next_st.a_valid = st.h_valid;               // RULE_05
      next_st.a_dig   = {st.h_res[9 -: WIDE_BITS], st.h_res[7 -: WIDE_BITS]}; // RULE_04
      next_st.a_res   = {st.h_res[5:0], 4'h0};    // residue amplified past two stages
      next_st.a_ovr   = st.h_ovr;                 // RULE_16
      // stages 3 and 4, earlier digits carried along for alignment
      next_st.b_valid = st.a_valid;               // RULE_05
      next_st.b_dig   = {st.a_dig, st.a_res[9 -: WIDE_BITS], st.a_res[7 -: WIDE_BITS]}; // RULE_06
      next_st.b_res   = {st.a_res[5:0], 4'h0};    // RULE_04
      next_st.b_ovr   = st.a_ovr;                 // RULE_16
      // stage 5 then the fifth residue into stage 6, merged in correction
      ob = {st.b_dig, st.b_res[9 -: NARROW_BITS], st.b_res[8 -: NARROW_BITS]}; // RULE_04 RULE_06
      next_st.c_valid = st.b_valid;                // RULE_03
      next_st.c_word  = {st.b_ovr, st.twos ? ~ob[9] : ob[9], ob[8:0]}; // RULE_15 RULE_11 RULE_14
    end else begin
      // nap and sleep stop conversion; nothing in flight is pushed afterwards
      next_st.h_valid = 1'b0;
      next_st.a_valid = 1'b0;
      next_st.b_valid = 1'b0;
      next_st.c_valid = 1'b0;
      if (output_enable_n) begin
        // sleep also drops the held residues, nap keeps them for a quicker restart
        next_st.h_res = '0;
        next_st.a_res = '0;
        next_st.b_res = '0;
      end
    end
  end

  // ==========================================================================
  // state register
  // ==========================================================================
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st <= STATE_RST;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // output buffer: the converter cannot wait, so a full buffer drops the word
  // ==========================================================================
  pas_fifo #(
    .WIDTH (BUF_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk       (clk),
    .nrst      (nrst),
    .clk_en    (clk_en),
    .in_valid  (st.c_valid),
    .in_data   (st.c_word),
    .in_ready  (buffer_ready),
    .out_valid (sample_valid),
    .out_data  (buf_word),
    .out_ready (capture_ready),
    .level     (buf_level)
  );

  // flag and word leave the same buffer flop, so they change together
  assign sample_word_bits    = buf_word[WORD_W-1:0];   // RULE_11
  assign range_exceeded_flag = buf_word[FLAG_POS];     // RULE_16
  assign sample_oe_n         = st.drive_n;
  assign duty_stabilizer_on  = st.stab_on;
  assign power_state         = st.pwr;

  // ==========================================================================
  // checks
  // ==========================================================================
  logic [2:0] run_cnt; // clocks of unbroken streaming with a drained buffer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      run_cnt <= 3'h0;
    end else if (clk_en && run && capture_ready && (buf_level <= 1)) begin
      run_cnt <= (run_cnt == 3'h7) ? 3'h7 : 3'(run_cnt + 3'h1);
    end else begin
      run_cnt <= 3'h0;
    end
  end

  a_word_latency: assert property (@(posedge clk) disable iff (!nrst) // RULE_03
    (run_cnt >= 3'h6) |-> sample_valid &&
      ({1'b0, sample_word_bits} == (exp_word($past(analog_in, 6), $past(mode_level, 4)) & 11'h3FF))
  ) else $error("sample word not five clocks behind its sample");

  a_flag_latency: assert property (@(posedge clk) disable iff (!nrst) // RULE_16
    (run_cnt >= 3'h6) |->
      ({range_exceeded_flag, 10'h000} == (exp_word($past(analog_in, 6), 2'h0) & 11'h400))
  ) else $error("range flag out of step with its word");

  a_flag_range: assert property (@(posedge clk) disable iff (!nrst) // RULE_12
    (clk_en && run) |=> (st.h_ovr == (($past(shifted) > CODE_TOP) || ($past(shifted) < 0)))
  ) else $error("range flag wrong for held input");

  a_midscale_codes: assert property (@(posedge clk) disable iff (!nrst) // RULE_14
    (run_cnt >= 3'h6 && $past(mode_level, 4) >= MODE_TWO_THIRDS && $past(analog_in, 6) == 0)
      |-> (sample_word_bits == 10'h000)
  ) else $error("mid scale does not read all zeros in twos complement");

  a_hold_sample: assert property (@(posedge clk) disable iff (!nrst) // RULE_02
    (clk_en && run) |=> st.h_valid &&
      ({1'b0, st.h_res} == (clip_code($past(analog_in)) & 11'h3FF))
  ) else $error("held sample does not match input at the edge");

  a_stage_walk: assert property (@(posedge clk) disable iff (!nrst) // RULE_04
    (clk_en && run && st.h_valid) ##1 (clk_en && run) ##1 (clk_en && run) |=> st.c_valid
  ) else $error("sample did not cross the stages in three clocks");

  a_drive_normal: assert property (@(posedge clk) disable iff (!nrst) // RULE_07
    (clk_en && !power_down_select && !output_enable_n) |=> !sample_oe_n && power_state == PAS_RUN
  ) else $error("outputs not driven in normal operation");

  a_hiz_running: assert property (@(posedge clk) disable iff (!nrst) // RULE_08
    (clk_en && !power_down_select && output_enable_n) |=> sample_oe_n && st.h_valid
  ) else $error("released outputs stopped conversion");

  a_nap_entry: assert property (@(posedge clk) disable iff (!nrst) // RULE_09
    (clk_en && power_down_select && !output_enable_n) |=>
      sample_oe_n && power_state == PAS_NAP && !st.h_valid
  ) else $error("nap not entered with outputs released");

  a_sleep_entry: assert property (@(posedge clk) disable iff (!nrst) // RULE_10
    (clk_en && power_down_select && output_enable_n) |=>
      sample_oe_n && power_state == PAS_SLEEP && st.h_res == '0
  ) else $error("sleep not entered with outputs released");

  a_mode_decode: assert property (@(posedge clk) disable iff (!nrst) // RULE_13
    clk_en |=> (duty_stabilizer_on == ($past(mode_level) == MODE_THIRD ||
                                       $past(mode_level) == MODE_TWO_THIRDS)) &&
               (st.twos == $past(mode_level[1]))
  ) else $error("mode pin decoded wrongly");

  a_freeze_low: assert property (@(posedge clk) disable iff (!nrst)
    !clk_en |=> $stable(st)
  ) else $error("state moved with clock enable low");

  c_stream: cover property (@(posedge clk) disable iff (!nrst) run_cnt == 3'h7);
  c_over: cover property (@(posedge clk) disable iff (!nrst)
    sample_valid && range_exceeded_flag);
  c_nap: cover property (@(posedge clk) disable iff (!nrst)
    power_state == PAS_RUN ##1 power_state == PAS_NAP);
  c_twos: cover property (@(posedge clk) disable iff (!nrst)
    run_cnt >= 3'h6 && st.twos && !sample_oe_n);

endmodule
`default_nettype wire

// >>> pas_capture_model.sv
// capture-side partner model: registers words taken from the converter pins
`timescale 1ns/10ps
`default_nettype none
module pas_capture_model
  import pas_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic [WORD_W-1:0] sample_word_bits,
  input  wire logic              range_exceeded_flag,
  input  wire logic              sample_oe_n,
  input  wire logic              sample_valid,
  input  wire logic [1:0]        power_state,
  input  wire logic              stall,
  output logic                   capture_ready
);
  logic [BUF_W-1:0] got[$];
  int               skip;
  int               dropped;
  logic [1:0]       pwr_q;

  // stalls come only from the bench, so buffer back-pressure is exercised on demand
  assign capture_ready = ~stall;

  // =========================================================================
  // capture on the rising edge; released pins are never read
  // =========================================================================
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      skip = 0;
      dropped = 0;
      pwr_q = 2'h3;
    end else begin
      // leaving nap or sleep: the first results are not trusted
      if (pwr_q[1] && !power_state[1]) begin
        skip = 5;
      end
      if (sample_valid && capture_ready && !sample_oe_n) begin
        if (skip > 0) begin
          skip--;
          dropped++;
        end else begin
          got.push_back({range_exceeded_flag, sample_word_bits});
        end
      end
      pwr_q = power_state;
    end
  end
endmodule
`default_nettype wire

// >>> pas_top_tb_top.sv
// self-checking bench for the converter sample output block and its capture partner
`timescale 1ns/10ps
`default_nettype none
module pas_top_tb_top;
  import pas_pkg::*;
  logic                    clk, nrst, clk_en, power_down_select, output_enable_n, stall;
  logic                    capture_ready, range_exceeded_flag, sample_oe_n, sample_valid;
  logic                    buffer_ready, duty_stabilizer_on;
  logic [1:0]              mode_level;
  logic signed [AIN_W-1:0] analog_in;
  logic [WORD_W-1:0]       sample_word_bits;
  pas_pwr_t                power_state;
  int                      failures, checks_done;

  pas_top #(.DEPTH(BUF_DEPTH)) pas_top_i (
    .clk(clk), .nrst(nrst), .clk_en(clk_en), .analog_in(analog_in),
    .power_down_select(power_down_select), .output_enable_n(output_enable_n),
    .mode_level(mode_level), .capture_ready(capture_ready),
    .sample_word_bits(sample_word_bits), .range_exceeded_flag(range_exceeded_flag),
    .sample_oe_n(sample_oe_n), .sample_valid(sample_valid), .buffer_ready(buffer_ready),
    .duty_stabilizer_on(duty_stabilizer_on), .power_state(power_state));

  pas_capture_model pas_capture_model_i (
    .clk(clk), .nrst(nrst), .sample_word_bits(sample_word_bits),
    .range_exceeded_flag(range_exceeded_flag), .sample_oe_n(sample_oe_n),
    .sample_valid(sample_valid), .power_state(power_state), .stall(stall),
    .capture_ready(capture_ready));

  // =========================================================================
  // clock, common tasks and expected codes
  // =========================================================================
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic check(input string what, input logic [19:0] seen, input logic [19:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // inputs always change 1 ns after the edge, clear of the sampling instant
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wrap_up();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // flag and word as the pins should show them; clipping saturates
  function automatic logic [BUF_W-1:0] expect_word(input int a, input logic twos);
    int               code;
    logic [BUF_W-1:0] w;
    code = a + 512;
    if (code > 1023) w = {1'b1, 10'h3FF};
    else if (code < 0) w = {1'b1, 10'h000};
    else w = {1'b0, code[9:0]};
    if (twos) w[9] = ~w[9];
    return w;
  endfunction

  // =========================================================================
  // scenarios
  // =========================================================================
  // sample t is driven before edge t and must stand on the pins after edge t+5
  task automatic stream(input int vals[$], input logic twos);
    int n;
    n = vals.size();
    for (int t = 0; t < n + 5; t++) begin
      if (t < n) analog_in = AIN_W'(vals[t]);
      step(1);
      if (t >= 5) begin
        check("word", {range_exceeded_flag, sample_word_bits}, expect_word(vals[t-5], twos));
        check("valid", sample_valid, 1'b1);
      end
    end
  endtask

  task automatic power_modes();
    for (int i = 0; i < 4; i++) begin
      {power_down_select, output_enable_n} = 2'(i);
      mode_level = 2'(i);
      step(1);
      check("power state", power_state, 20'(i));
      check("pin enable", sample_oe_n, 20'(i != 0));
      check("stabilizer", duty_stabilizer_on, 20'(i == 1 || i == 2));
    end
    {power_down_select, output_enable_n} = 2'h0;
    step(2);
  endtask

  // every mode code, with both clip edges and the two codes around mid scale
  task automatic formats();
    for (int m = 0; m < 4; m++) begin
      mode_level = 2'(m);
      step(3);
      stream('{-900, -513, -512, -1, 0, 511, 512, 1500}, m[1]);
    end
    mode_level = MODE_GND;
  endtask

  task automatic fill_drain();
    int k;
    // settle so the output flop and the words already in flight all carry the first value
    analog_in = AIN_W'(-240);
    step(8);
    stall = 1'b1;
    for (int t = 0; t < 24; t++) begin
      analog_in = AIN_W'(t * 20 - 240);
      step(1);
    end
    check("buffer full", buffer_ready, 1'b0);
    stall = 1'b0;
    // the oldest word stands through the stall, then the buffer pours out in order
    for (int j = 0; j < BUF_DEPTH; j++) begin
      check("drain word", {range_exceeded_flag, sample_word_bits}, expect_word((j > 6 ? j - 6 : 0) * 20 - 240, 1'b0));
      step(1);
    end
    power_down_select = 1'b1;
    for (k = 0; k < 40 && sample_valid !== 1'b0; k++) step(1);
    check("drain bound", k < 40, 1'b1);
    if (k == 40) wrap_up();
    check("drained", buffer_ready, 1'b1);
    power_down_select = 1'b0;
    step(2);
  endtask

  task automatic nap_wake();
    int d0;
    power_down_select = 1'b1;
    step(8);
    check("nap state", power_state, PAS_NAP);
    check("nap quiet", {sample_valid, sample_oe_n}, 2'h1);
    d0 = pas_capture_model_i.dropped;
    power_down_select = 1'b0;
    step(2);
    stream('{1, 2, 3, 4, 5, 6, 7, 8}, 1'b0);
    check("wake discard", pas_capture_model_i.dropped - d0, 5);
    step(1);
    check("captured", pas_capture_model_i.got[$], expect_word(8, 1'b0));
  endtask

  task automatic freeze();
    logic [WORD_W-1:0] w;
    for (int t = 0; t < 8; t++) begin
      analog_in = AIN_W'(t * 37);
      step(1);
    end
    clk_en = 1'b0;
    w = sample_word_bits;
    analog_in = -AIN_W'(300);
    output_enable_n = 1'b1;
    step(3);
    check("frozen word", sample_word_bits, w);
    check("frozen state", power_state, PAS_RUN);
    clk_en = 1'b1;
    output_enable_n = 1'b0;
    step(8);
  endtask

  // a hang anywhere ends in the same report
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    wrap_up();
  end

  initial begin
    nrst = 1'b0;
    clk_en = 1'b1;
    analog_in = '0;
    power_down_select = 1'b0;
    output_enable_n = 1'b0;
    mode_level = MODE_GND;
    stall = 1'b0;
    failures = 0;
    checks_done = 0;
    step(4);
    check("reset outputs", {sample_word_bits, range_exceeded_flag, sample_valid, buffer_ready,
          sample_oe_n, duty_stabilizer_on, power_state}, {10'h000, 5'h06, 2'h3});
    nrst = 1'b1;
    step(2);
    power_modes();
    formats();
    fill_drain();
    nap_wake();
    freeze();
    wrap_up();
  end
endmodule
`default_nettype wire
